// [rtl/plpd_cfg.svh]
`ifndef PLPD_CFG_SVH
`define PLPD_CFG_SVH
// register byte addresses on the host port
`define PLPD_ADDR_W 16
`define PLPD_ADDR_LOCK 16'h0069
`define PLPD_ADDR_CODE 16'h006a
`define PLPD_ADDR_PUMP 16'h006c
`define PLPD_ADDR_REF 16'h006d
`define PLPD_ADDR_XTAL 16'h006e
`define PLPD_ADDR_OUT 16'h006f
`define PLPD_ADDR_LOOP 16'h0070
// field positions
`define PLPD_LOCK_OVR_BIT 0
`define PLPD_CODE_LSB 0
`define PLPD_CODE_MSB 4
`define PLPD_PUMP_LSB 0
`define PLPD_PUMP_MSB 4
`define PLPD_REF0_BIT 3
`define PLPD_REF1_BIT 4
`define PLPD_RELEASE_BIT 1
`define PLPD_DBL_BIT 0
`define PLPD_OUT_LSB 1
`define PLPD_OUT_CNT 4
`define PLPD_CAL_BIT 0
`define PLPD_DSM_BIT 1
`define PLPD_DPLL_BIT 2
// reset values
`define PLPD_CODE_RST 5'h0b
`define PLPD_PUMP_RST 5'h00
`define PLPD_BIT_RST 1'h0
`define PLPD_ALARM_RST 1'h1
`define PLPD_BYTE_ZERO 8'h00
`endif

// [rtl/plpd_pkg.sv]
package plpd_pkg;
  // lock alarm release state
  typedef enum logic [1:0] {
    PLPD_UNLOCKED = 2'h0,
    PLPD_LOCKED = 2'h1,
    PLPD_RELEASED = 2'h3
  } plpd_alarm_type;
endpackage

// [rtl/plpd_alarm.sv]
`timescale 1ns/10ps
`include "plpd_cfg.svh"
// loss-of-lock alarm release sequencer
module plpd_alarm
  import plpd_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // loop status
  input wire logic i_mode,
  input wire logic i_locked,
  input wire logic i_out_stable,
  // alarm
  output logic o_loss_of_lock_alarm
);
  typedef struct packed {
    plpd_alarm_type st;
    logic alarm;
  } plpd_alarm_state_type;
  plpd_alarm_state_type s_reg; // registered state
  plpd_alarm_state_type s_next; // next state
  // state machine: release when locked, optionally waiting for stable outputs
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      PLPD_UNLOCKED: begin
        if (i_locked) begin
          s_next.st = PLPD_LOCKED;
        end
      end
      PLPD_LOCKED: begin
        if (!i_locked) begin
          s_next.st = PLPD_UNLOCKED;
        end else if (!i_mode || i_out_stable) begin
          s_next.st = PLPD_RELEASED;
        end
      end
      PLPD_RELEASED: begin
        if (!i_locked) begin
          s_next.st = PLPD_UNLOCKED;
        end
      end
      default: begin
        s_next.st = PLPD_UNLOCKED;
      end
    endcase
    s_next.alarm = (s_next.st != PLPD_RELEASED);
  end
  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_reg <= '{st: PLPD_UNLOCKED, alarm: `PLPD_ALARM_RST};
    end else begin
      s_reg <= s_next;
    end
  end
  assign o_loss_of_lock_alarm = s_reg.alarm;
endmodule // plpd_alarm

// [rtl/plpd_top.sv]
`timescale 1ns/10ps
`include "plpd_cfg.svh"
// Functional notes
// - override bit picks auto or manual code
// - five-bit pump current code, reset zero
// - per-reference disable bit, reset zero
// - alarm release waits lock, optionally stable
// - doubler bypass picks crystal times one/two
// - output disable shuts logic, driver hi-z
// - digital loop disable bit, reset zero
// - modulator disable bit, reset zero
// - calibration reset holds calibration off
// - reserved bits written zero, read zero
// - power-down bytes at 006D through 0070
module plpd_top
  import plpd_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // host register port (byte wide)
  input wire logic [`PLPD_ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // loop status
  input wire logic i_locked,
  input wire logic i_out_stable,
  input wire logic [4:0] i_auto_lock_code,
  // control to analog and digital loops
  output logic [4:0] o_lock_code,
  output logic o_lock_override_select,
  output logic [4:0] o_pump_current_code,
  output logic [1:0] o_ref_input_off,
  output logic o_crystal_doubler_bypass,
  output logic o_ref_doubled,
  output logic [3:0] o_output_off,
  output logic [3:0] o_output_oe,
  output logic o_digital_loop_off,
  output logic o_modulator_off,
  output logic o_calibration_reset,
  output logic o_loss_of_lock_alarm
);
  typedef struct packed {
    logic lock_ovr; // manual lock select
    logic [4:0] code; // manual lock code
    logic [4:0] pump; // pump current code
    logic [1:0] ref_off; // input disables
    logic release_mode; // alarm release mode
    logic dbl_byp; // doubler bypass
    logic [3:0] out_off; // output disables
    logic dpll_off; // digital loop disable
    logic dsm_off; // modulator disable
    logic cal_rst; // calibration reset
    logic [7:0] rdata; // read data
    logic rvalid; // read strobe
  } plpd_state_type;
  plpd_state_type s_reg; // registered state
  plpd_state_type s_next; // next state
  logic [4:0] lock_code_next; // selected lock code
  logic [7:0] rd_byte; // read-back value of the addressed byte
  logic [3:0] oe_bits; // per-output driver enables
  // one select per register byte; at most one is high
  logic sel_lock; // lock override byte
  logic sel_code; // manual lock code byte
  logic sel_pump; // pump current byte
  logic sel_ref; // reference disable byte
  logic sel_xtal; // doubler and alarm release byte
  logic sel_out; // output disable byte
  logic sel_loop; // loop block disable byte

  // address decode shared by the write and read paths
  // an address outside the map raises no select, so a write
  // there is dropped and a read there answers zero
  always_comb begin
    sel_lock = (i_addr == `PLPD_ADDR_LOCK); // override byte
    sel_code = (i_addr == `PLPD_ADDR_CODE); // manual code byte
    sel_pump = (i_addr == `PLPD_ADDR_PUMP); // pump code byte
    sel_ref = (i_addr == `PLPD_ADDR_REF); // first power-down byte
    sel_xtal = (i_addr == `PLPD_ADDR_XTAL);
    sel_out = (i_addr == `PLPD_ADDR_OUT);
    sel_loop = (i_addr == `PLPD_ADDR_LOOP); // last power-down byte
  end

  // read-back byte built from the registered fields
  // a read in the same cycle as a write to the same byte
  // therefore returns the value held before that write
  always_comb begin
    rd_byte = `PLPD_BYTE_ZERO; // reserved positions read zero
    if (sel_lock) begin
      // override select in the lowest position
      rd_byte[`PLPD_LOCK_OVR_BIT] = s_reg.lock_ovr;
    end
    if (sel_code) begin
      // manual lock code field
      rd_byte[`PLPD_CODE_MSB:`PLPD_CODE_LSB] = s_reg.code;
    end
    if (sel_pump) begin
      // pump current code field
      rd_byte[`PLPD_PUMP_MSB:`PLPD_PUMP_LSB] = s_reg.pump;
    end
    if (sel_ref) begin
      // one disable bit per input reference
      rd_byte[`PLPD_REF0_BIT] = s_reg.ref_off[0];
      rd_byte[`PLPD_REF1_BIT] = s_reg.ref_off[1];
    end
    if (sel_xtal) begin
      // alarm release mode and doubler bypass
      rd_byte[`PLPD_RELEASE_BIT] = s_reg.release_mode;
      rd_byte[`PLPD_DBL_BIT] = s_reg.dbl_byp;
    end
    if (sel_out) begin
      // four output disables, output 0 lowest
      rd_byte[`PLPD_OUT_LSB+:`PLPD_OUT_CNT] = s_reg.out_off;
    end
    if (sel_loop) begin
      // digital loop, modulator and calibration controls
      rd_byte[`PLPD_DPLL_BIT] = s_reg.dpll_off;
      rd_byte[`PLPD_DSM_BIT] = s_reg.dsm_off;
      rd_byte[`PLPD_CAL_BIT] = s_reg.cal_rst;
    end
  end

  // next state: field writes, read answer and read strobe
  always_comb begin
    s_next = s_reg; // fields hold until written
    s_next.rvalid = i_rd; // answer stands one cycle after the strobe
    s_next.rdata = `PLPD_BYTE_ZERO; // data only stands with the answer
    if (i_rd) begin
      // capture the addressed byte for the answer cycle
      s_next.rdata = rd_byte;
    end
    if (i_wr) begin
      // only field positions are taken; reserved positions are dropped
      if (sel_lock) begin
        // automatic or manual lock control
        s_next.lock_ovr = i_wdata[`PLPD_LOCK_OVR_BIT];
      end
      if (sel_code) begin
        // code used while manual lock control is selected
        s_next.code = i_wdata[`PLPD_CODE_MSB:`PLPD_CODE_LSB];
      end
      if (sel_pump) begin
        // every one of the 32 codes is a legal current step
        s_next.pump = i_wdata[`PLPD_PUMP_MSB:`PLPD_PUMP_LSB];
      end
      if (sel_ref) begin
        // reference inputs switched off independently
        s_next.ref_off[0] = i_wdata[`PLPD_REF0_BIT];
        s_next.ref_off[1] = i_wdata[`PLPD_REF1_BIT];
      end
      if (sel_xtal) begin
        // release mode is followed from the next cycle on, also while a lock waits for release
        s_next.release_mode = i_wdata[`PLPD_RELEASE_BIT];
        s_next.dbl_byp = i_wdata[`PLPD_DBL_BIT];
      end
      if (sel_out) begin
        // output disables, output 0 in the lowest field position
        s_next.out_off = i_wdata[`PLPD_OUT_LSB+:`PLPD_OUT_CNT];
      end
      if (sel_loop) begin
        // loop block disables
        s_next.dpll_off = i_wdata[`PLPD_DPLL_BIT];
        s_next.dsm_off = i_wdata[`PLPD_DSM_BIT];
        s_next.cal_rst = i_wdata[`PLPD_CAL_BIT];
      end
    end
  end

  // state register; reset loads the defaults of every field
  // the reset is synchronous, so fields only move on clock edges
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      // analog loop control fields
      s_reg.lock_ovr <= `PLPD_BIT_RST;
      s_reg.code <= `PLPD_CODE_RST;
      s_reg.pump <= `PLPD_PUMP_RST;
      // power-down fields: everything enabled after reset
      s_reg.ref_off <= {2{`PLPD_BIT_RST}};
      s_reg.release_mode <= `PLPD_BIT_RST;
      s_reg.dbl_byp <= `PLPD_BIT_RST;
      s_reg.out_off <= {4{`PLPD_BIT_RST}};
      s_reg.dpll_off <= `PLPD_BIT_RST;
      s_reg.dsm_off <= `PLPD_BIT_RST;
      s_reg.cal_rst <= `PLPD_BIT_RST;
      // host answer idle
      s_reg.rdata <= `PLPD_BYTE_ZERO;
      s_reg.rvalid <= `PLPD_BIT_RST;
    end else begin
      // take the next state
      s_reg <= s_next;
    end
  end

  // lock code source: automatic control value or manual field
  // the manual code reaches the loop only while override is set
  always_comb begin
    if (s_reg.lock_ovr) begin
      // manual lock control
      lock_code_next = s_reg.code;
    end else begin
      // automatic lock control
      lock_code_next = i_auto_lock_code;
    end
  end

  // per-output driver enables, high while the output drives its pins
  // a disabled output holds its driver released
  for (genvar g = 0; g < `PLPD_OUT_CNT; g++) begin : g_out
    assign oe_bits[g] = ~s_reg.out_off[g];
  end

  // alarm release sequencer; it follows the release mode field
  plpd_alarm u_alarm (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_mode(s_reg.release_mode),
    .i_locked(i_locked),
    .i_out_stable(i_out_stable),
    .o_loss_of_lock_alarm(o_loss_of_lock_alarm)
  );

  // host answer
  assign o_rdata = s_reg.rdata;
  assign o_rvalid = s_reg.rvalid;
  // analog loop controls
  assign o_lock_code = lock_code_next;
  assign o_lock_override_select = s_reg.lock_ovr;
  assign o_pump_current_code = s_reg.pump;
  // reference and doubler controls
  assign o_ref_input_off = s_reg.ref_off;
  assign o_crystal_doubler_bypass = s_reg.dbl_byp;
  assign o_ref_doubled = ~s_reg.dbl_byp;
  // output controls
  assign o_output_off = s_reg.out_off;
  assign o_output_oe = oe_bits;
  // loop block controls
  assign o_digital_loop_off = s_reg.dpll_off;
  assign o_modulator_off = s_reg.dsm_off;
  assign o_calibration_reset = s_reg.cal_rst;
endmodule // plpd_top

// [dv/plpd_checker.sv]
`timescale 1ns/10ps
`include "plpd_cfg.svh"
// watches host writes, derived outputs and alarm release
module plpd_checker (
  // clock, reset and host port
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [`PLPD_ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic o_rvalid,
  // loop status and controls
  input wire logic i_locked,
  input wire logic [4:0] i_auto_lock_code,
  input wire logic [4:0] o_lock_code,
  input wire logic o_lock_override_select,
  input wire logic [4:0] o_pump_current_code,
  input wire logic [3:0] o_output_off,
  input wire logic [3:0] o_output_oe,
  input wire logic o_crystal_doubler_bypass,
  input wire logic o_ref_doubled,
  input wire logic o_loss_of_lock_alarm
);
  logic [7:0] wd_reg; // write data one cycle back
  always_ff @(posedge i_clk) wd_reg <= i_wdata;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_auto; !o_lock_override_select |-> o_lock_code == i_auto_lock_code; endproperty
  a_auto: assert property (p_auto) else $error("auto lock code");
  property p_oe; o_output_oe == ~o_output_off; endproperty
  a_oe: assert property (p_oe) else $error("output enable");
  property p_dbl; o_ref_doubled == !o_crystal_doubler_bypass; endproperty
  a_dbl: assert property (p_dbl) else $error("doubler select");
  property p_rv; i_rd |=> o_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read answer");
  property p_out; i_wr && i_addr == `PLPD_ADDR_OUT |=> o_output_off == wd_reg[4:1]; endproperty
  a_out: assert property (p_out) else $error("output off write");
  property p_pump; i_wr && i_addr == `PLPD_ADDR_PUMP |=> o_pump_current_code == wd_reg[4:0];
  endproperty
  a_pump: assert property (p_pump) else $error("pump code write");
  property p_alarm_up; !i_locked |=> o_loss_of_lock_alarm; endproperty
  a_alarm_up: assert property (p_alarm_up) else $error("alarm not raised");
  property p_rv_idle; !i_rd |=> !o_rvalid; endproperty
  a_rv_idle: assert property (p_rv_idle) else $error("stray read answer");
  property p_rel; $fell(o_loss_of_lock_alarm) |-> $past(i_locked) && $past(i_locked, 2); endproperty
  a_rel: assert property (p_rel) else $error("early release");
  cover property (i_wr && i_addr == `PLPD_ADDR_OUT);
  cover property ($fell(o_loss_of_lock_alarm));
  cover property (o_lock_override_select && i_rd);
endmodule // plpd_checker
bind plpd_top plpd_checker i_chk (.i_clk, .i_rst_n, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rvalid,
  .i_locked, .i_auto_lock_code, .o_lock_code, .o_lock_override_select, .o_pump_current_code,
  .o_output_off, .o_output_oe, .o_crystal_doubler_bypass, .o_ref_doubled, .o_loss_of_lock_alarm);

// [dv/plpd_tb.sv]
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, lk = 1'b0, st = 1'b0;
  logic [15:0] ad = 16'h0000;
  logic [7:0] wd = 8'h00, rdat;
  logic [4:0] ac = 5'h06, lc, pc;
  logic [3:0] oo, oe;
  logic [1:0] ro;
  logic rv, ov, bp, dbl, dl, dm, cr, al;
  int fail_count = 0, checks = 0, cyc = 0;
  // register offsets, test values and reset values
  logic [7:0] ta [7] = '{8'h69, 8'h6a, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70};
  logic [7:0] tv [7] = '{8'h01, 8'h15, 8'h1f, 8'h18, 8'h03, 8'h1e, 8'h07};
  logic [7:0] td [7] = '{8'h00, 8'h0b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  plpd_top i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(ad), .i_wr(wr), .i_rd(rd),
    .i_wdata(wd), .o_rdata(rdat), .o_rvalid(rv), .i_locked(lk), .i_out_stable(st),
    .i_auto_lock_code(ac), .o_lock_code(lc), .o_lock_override_select(ov),
    .o_pump_current_code(pc), .o_ref_input_off(ro), .o_crystal_doubler_bypass(bp),
    .o_ref_doubled(dbl), .o_output_off(oo), .o_output_oe(oe), .o_digital_loop_off(dl),
    .o_modulator_off(dm), .o_calibration_reset(cr), .o_loss_of_lock_alarm(al));
  always #10 clk = ~clk;
  // cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // one-cycle write strobe, driven at the falling edge
  task automatic wr8(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    ad = {8'h00, a};
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // read strobe; answer stands in the following cycle
  task automatic rd8(logic [7:0] a, logic [7:0] e);
    @(negedge clk);
    ad = {8'h00, a};
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, rv});
    chk("rdata", e, rdat);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 7; i++) rd8(ta[i], td[i]);
    chk("oe", 8'h0f, {4'h0, oe});
    chk("doubled", 8'h01, {7'h00, dbl});
    chk("lock_code", 8'h06, {3'h0, lc});
    chk("cal", 8'h00, {7'h00, cr});
    chk("override", 8'h00, {7'h00, ov});
    $display("test reset_values done");
    // alarm released two cycles after lock, without waiting for stable outputs
    lk = 1'b1;
    repeat (3) @(negedge clk);
    chk("alarm", 8'h00, {7'h00, al});
    lk = 1'b0;
    @(negedge clk);
    chk("alarm", 8'h01, {7'h00, al});
    $display("test release_mode0 done");
    // every field written then read back, the read one idle cycle after the write
    for (int i = 0; i < 7; i++) begin
      wr8(ta[i], tv[i]);
      rd8(ta[i], tv[i]);
    end
    chk("ref_off", 8'h03, {6'h00, ro});
    chk("bypass", 8'h01, {7'h00, bp});
    chk("doubled", 8'h00, {7'h00, dbl});
    chk("oe", 8'h00, {4'h0, oe});
    chk("loop_bits", 8'h07, {5'h00, dl, dm, cr});
    chk("pump", 8'h1f, {3'h0, pc});
    chk("lock_code", 8'h15, {3'h0, lc});
    chk("override", 8'h01, {7'h00, ov});
    chk("out_off", 8'h0f, {4'h0, oo});
    $display("test readback done");
    // release mode 1 waits for stable outputs
    lk = 1'b1;
    repeat (4) @(negedge clk);
    chk("alarm", 8'h01, {7'h00, al});
    st = 1'b1;
    repeat (3) @(negedge clk);
    chk("alarm", 8'h00, {7'h00, al});
    $display("test release_mode1 done");
    // unmapped places answer zero and disturb nothing
    wr8(8'h71, 8'h55);
    rd8(8'h71, 8'h00);
    rd8(8'h6b, 8'h00);
    rd8(8'h70, 8'h07);
    $display("test unmapped done");
    // single bits land in their own positions
    wr8(8'h6d, 8'h08);
    chk("ref_off", 8'h01, {6'h00, ro});
    wr8(8'h6f, 8'h0a);
    chk("out_off", 8'h05, {4'h0, oo});
    chk("oe", 8'h0a, {4'h0, oe});
    wr8(8'h70, 8'h05);
    chk("loop_bits", 8'h05, {5'h00, dl, dm, cr});
    $display("test single_bits done");
    // reset in mid-run restores defaults
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 7; i++) rd8(ta[i], td[i]);
    chk("oe", 8'h0f, {4'h0, oe});
    chk("lock_code", 8'h06, {3'h0, lc});
    $display("test rerun_reset done");
    // manual mode drives the default manual code
    wr8(8'h69, 8'h01);
    chk("override", 8'h01, {7'h00, ov});
    chk("lock_code", 8'h0b, {3'h0, lc});
    $display("test manual_default done");
    give_verdict();
  end
endmodule // tb
